// >>> cst_pkg.sv
// Package for the composite sync timing offset block: register map, field codes,
// reset values, timing counts and the configuration carriers.
// Assumes a 250 MHz APB clock and a master sample tick of one 18.5 ns step.
package cst_pkg;
	// Register byte addresses.
	localparam logic [7:0] CST_CTRL = 8'h00;
	localparam logic [7:0] CST_CMP_FMT = 8'h04;
	localparam logic [7:0] CST_CMP_VOFF = 8'h08;
	localparam logic [7:0] CST_CMP_HOFF = 8'h0C;
	localparam logic [7:0] CST_CMP_TC = 8'h10;
	localparam logic [7:0] CST_CMP_TCOFF = 8'h14;
	localparam logic [7:0] CST_CMP_POS = 8'h18;
	localparam logic [7:0] CST_BLANK = 8'h1C;
	localparam logic [7:0] CST_TRI_RATE = 8'h20;
	localparam logic [7:0] CST_BLK_BASE = 8'h40;
	localparam logic [7:0] CST_BLK_END = 8'h90;
	localparam logic [7:0] CST_BLK_FMT = 8'h00;
	localparam logic [7:0] CST_BLK_VOFF = 8'h04;
	localparam logic [7:0] CST_BLK_HOFF = 8'h08;
	localparam logic [7:0] CST_BLK_TCOFF = 8'h0C;
	// CTRL bits.
	localparam int CST_CTRL_SEL_ADV = 0;
	localparam int CST_CTRL_OFF_CLR = 1;
	localparam int CST_CTRL_RECALL = 2;
	localparam int CST_STAT_LOCK = 1;
	// Field positions.
	localparam int CST_TEST_LSB = 8;
	localparam int CST_FREF_BIT = 4;
	localparam int CST_SRC_LSB = 8;
	localparam int CST_DROP_BIT = 11;
	localparam int CST_BLANK_EN_BIT = 20;
	localparam int CST_SAMPLE_LSB = 16;
	// Format codes.
	localparam logic [1:0] CST_FMT_NTSC = 2'h0;
	localparam logic [1:0] CST_FMT_NTSC_J = 2'h1;
	localparam logic [1:0] CST_FMT_PAL = 2'h2;
	localparam logic [1:0] CST_FMT_HD = 2'h3;
	// Test signal counts per family.
	localparam logic [3:0] CST_TEST_NTSC_CNT = 4'hC;
	localparam logic [3:0] CST_TEST_PAL_CNT = 4'hB;
	// Offset ranges.
	localparam int CST_STEP_PS = 18500;
	localparam int CST_NTSC_LINE_PS = 63555600;
	localparam int CST_PAL_LINE_PS = 64000000;
	localparam int CST_H_NTSC = CST_NTSC_LINE_PS / CST_STEP_PS;
	localparam int CST_H_PAL = CST_PAL_LINE_PS / CST_STEP_PS;
	localparam int CST_V_NTSC = 525;
	localparam int CST_V_PAL = 1250;
	localparam int CST_FINE_MAX_NS = 10;
	// Timecode limits.
	localparam int CST_TC_HH_MAX = 23;
	localparam int CST_TC_MS_MAX = 59;
	localparam int CST_TC_FF_NTSC = 29;
	localparam int CST_TC_FF_PAL = 24;
	// Blank-on-unlock delay, seconds.
	localparam int CST_CLK_NS = 4;
	localparam int CST_SEC_CYCLES = 1000000000 / CST_CLK_NS;
	localparam logic [16:0] CST_BLANK_DLY_RST = 17'h0000A;
	localparam int CST_BLANK_OUT = 1;
	localparam int CST_N_BLK = 5;

	typedef struct packed {
		logic neg;
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
		logic [4:0] ff;
	} cst_tc_type;

	typedef struct packed {
		logic [1:0] fmt;
		logic [3:0] test;
		logic signed [11:0] voff;
		logic signed [12:0] hoff;
		logic [2:0] tc_src;
		logic drop;
		cst_tc_type tc_off;
	} cst_cmp_type;

	typedef struct packed {
		logic [1:0] fmt;
		logic fref;
		logic signed [11:0] voff;
		logic signed [15:0] coarse;
		logic signed [7:0] fine;
		logic [2:0] tc_src;
		logic drop;
		cst_tc_type tc_off;
	} cst_blk_type;

	typedef struct packed {
		logic [11:0] line;
		logic [11:0] sample;
	} cst_pos_type;
endpackage : cst_pkg

// >>> cst_timing.sv
// Composite sync timing offset block: APB register file, two composite output
// configurations with line/sample counters, and reference-burst output settings.
// Assumes sample_tick and int_frame_start come from the generator timebase on pclk;
// genlock pins are asynchronous and synchronised here.
//
// Contract
// - Composite horizontal offset spans minus one to plus one line, one 18.5 ns step.
// - Composite vertical offset spans 525 lines NTSC, 1250 lines PAL, either way.
// - Horizontal offset limited to 63.5556 us NTSC and 64.0000 us PAL.
// - Reset-offset command clears vertical and horizontal offset of selected output.
// - Offsets measured from genlock when locked, else from internal reference.
// - NTSC family offers twelve test signals, PAL eleven.
// - Format change may shock sync; downstream must tolerate loss of lock.
// - Two independent composite outputs; select command steps to the next.
// - Recall sets black outputs NTSC, field reference off, all offsets zero.
// - Recall disables timecode, zeroes its offset, enables drop frame (NTSC only).
// - Blank-on-unlock only on black output two; recall disables, delay ten seconds.
// - Separate tri-level rate for outputs one-three and four-five; recall non-integer.
// - Field reference and timecode act only on non-HD black formats.
// - Timecode offset up to 23:59:59:29, frames bounded by format frame rate.
`timescale 1ns/10ps
module cst_timing
	import cst_pkg::*;
#(
	parameter int SEC_CYCLES = CST_SEC_CYCLES
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reference timing
	input wire logic sample_tick,
	input wire logic int_frame_start,
	input wire logic genlock_frame_pin,
	input wire logic genlock_locked_pin,
	// Composite outputs
	output cst_cmp_type [1:0] cmp_cfg,
	output cst_pos_type [1:0] cmp_pos,
	output logic [1:0] cmp_sync_shock,
	output logic composite_output_select,
	// Reference burst outputs
	output cst_blk_type [CST_N_BLK-1:0] reference_burst_outputs,
	output logic blank_second_output,
	output logic tri_rate_low_integer,
	output logic tri_rate_high_integer
);
	cst_cmp_type cmp_reg [2];
	cst_blk_type blk_reg [CST_N_BLK];
	cst_pos_type pos_reg [2];
	logic sel_reg;
	logic blank_en_reg;
	logic [16:0] blank_dly_reg;
	logic [1:0] tri_reg;
	logic [1:0] shock_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [2:0] gl_frame_sync_reg;
	logic [1:0] gl_lock_sync_reg;
	logic [31:0] sec_cnt_reg;
	logic [16:0] unlock_sec_reg;
	logic blank_reg;

	logic wr_en;
	logic setup;
	logic ref_start;
	logic ref_locked;
	logic cmd_adv;
	logic cmd_clr;
	logic cmd_recall;
	logic blk_hit;
	logic [2:0] blk_idx;
	logic [7:0] blk_off;

	function automatic logic is_pal(input logic [1:0] fmt);
		return fmt == CST_FMT_PAL;
	endfunction : is_pal

	function automatic logic v_ok(input logic [1:0] fmt, input logic signed [31:0] v);
		int lim;
		lim = is_pal(fmt) ? CST_V_PAL : CST_V_NTSC;
		return (v <= lim) && (v >= -lim);
	endfunction : v_ok

	function automatic logic h_ok(input logic [1:0] fmt, input logic signed [31:0] h);
		int lim;
		lim = is_pal(fmt) ? CST_H_PAL : CST_H_NTSC;
		return (h <= lim) && (h >= -lim);
	endfunction : h_ok

	function automatic logic tc_ok(input logic [1:0] fmt, input cst_tc_type t);
		int ffmax;
		ffmax = is_pal(fmt) ? CST_TC_FF_PAL : CST_TC_FF_NTSC;
		return (32'(t.hh) <= CST_TC_HH_MAX) && (32'(t.mm) <= CST_TC_MS_MAX) &&
			(32'(t.ss) <= CST_TC_MS_MAX) && (32'(t.ff) <= ffmax);
	endfunction : tc_ok

	function automatic logic test_ok(input logic [1:0] fmt, input logic [3:0] t);
		return t < (is_pal(fmt) ? CST_TEST_PAL_CNT : CST_TEST_NTSC_CNT);
	endfunction : test_ok

	// Counter preload: a negative horizontal offset borrows one line.
	function automatic cst_pos_type preload(input cst_cmp_type c);
		cst_pos_type p;
		logic signed [13:0] l;
		logic signed [13:0] s;
		logic signed [13:0] len;
		logic signed [13:0] frame;
		len = is_pal(c.fmt) ? 14'(CST_H_PAL) : 14'(CST_H_NTSC);
		frame = is_pal(c.fmt) ? 14'(2 * CST_V_PAL) : 14'(2 * CST_V_NTSC);
		s = 14'(c.hoff);
		l = 14'(c.voff);
		if (s < 0)
		begin
			s = s + len;
			l = l - 14'sd1;
		end
		if (s >= len)
		begin
			s = s - len;
			l = l + 14'sd1;
		end
		if (l < 0)
			l = l + frame;
		else if (l >= frame)
			l = l - frame;
		p.line = 12'(l);
		p.sample = 12'(s);
		return p;
	endfunction : preload

	function automatic cst_cmp_type cmp_default();
		cst_cmp_type c;
		c = '0;
		c.fmt = CST_FMT_NTSC;
		c.drop = 1'b1;
		return c;
	endfunction : cmp_default

	function automatic cst_blk_type blk_default();
		cst_blk_type b;
		b = '0;
		b.fmt = CST_FMT_NTSC;
		b.drop = 1'b1;
		return b;
	endfunction : blk_default

	assign setup = psel && !penable;
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign cmd_adv = wr_en && paddr == CST_CTRL && pwdata[CST_CTRL_SEL_ADV];
	assign cmd_clr = wr_en && paddr == CST_CTRL && pwdata[CST_CTRL_OFF_CLR];
	assign cmd_recall = wr_en && paddr == CST_CTRL && pwdata[CST_CTRL_RECALL];
	assign blk_hit = paddr >= CST_BLK_BASE && paddr < CST_BLK_END;
	assign blk_idx = 3'((paddr - CST_BLK_BASE) >> 4);
	assign blk_off = {4'h0, paddr[3:0]};

	// Genlock pins pass two flip-flops; the third stage only feeds the edge detector.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gl_frame_sync_reg <= '0;
			gl_lock_sync_reg <= '0;
		end
		else
		begin
			gl_frame_sync_reg <= {gl_frame_sync_reg[1:0], genlock_frame_pin};
			gl_lock_sync_reg <= {gl_lock_sync_reg[0], genlock_locked_pin};
		end
	end

	assign ref_locked = gl_lock_sync_reg[1];
	assign ref_start = ref_locked ? (gl_frame_sync_reg[1] && !gl_frame_sync_reg[2]) : int_frame_start;

	// Output select.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sel_reg <= 1'b0;
		else if (cmd_recall)
			sel_reg <= 1'b0;
		else if (cmd_adv)
			sel_reg <= ~sel_reg;
	end

	// Composite configuration; writes act on the selected output only, except recall, which resets both.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmp_reg[0] <= cmp_default();
			cmp_reg[1] <= cmp_default();
			shock_reg <= '0;
		end
		else
		begin
			shock_reg <= '0;
			if (cmd_recall)
			begin
				cmp_reg[0] <= cmp_default();
				cmp_reg[1] <= cmp_default();
			end
			else if (cmd_clr)
			begin
				cmp_reg[sel_reg].voff <= '0;
				cmp_reg[sel_reg].hoff <= '0;
			end
			else if (wr_en && paddr == CST_CMP_FMT && pwdata[1:0] != CST_FMT_HD)
			begin
				// A new family may not fit the old offsets, so vertical and horizontal both restart at zero.
				if (pwdata[1:0] != cmp_reg[sel_reg].fmt)
				begin
					cmp_reg[sel_reg].fmt <= pwdata[1:0];
					cmp_reg[sel_reg].voff <= '0;
					cmp_reg[sel_reg].hoff <= '0;
					shock_reg[sel_reg] <= 1'b1;
				end
				if (test_ok(pwdata[1:0], pwdata[CST_TEST_LSB +: 4]))
					cmp_reg[sel_reg].test <= pwdata[CST_TEST_LSB +: 4];
				else
					cmp_reg[sel_reg].test <= '0;
			end
			else if (wr_en && paddr == CST_CMP_VOFF && v_ok(cmp_reg[sel_reg].fmt, 32'(signed'(pwdata[11:0]))))
				cmp_reg[sel_reg].voff <= pwdata[11:0];
			else if (wr_en && paddr == CST_CMP_HOFF && h_ok(cmp_reg[sel_reg].fmt, 32'(signed'(pwdata[12:0]))))
				cmp_reg[sel_reg].hoff <= pwdata[12:0];
			else if (wr_en && paddr == CST_CMP_TC)
			begin
				cmp_reg[sel_reg].tc_src <= pwdata[CST_SRC_LSB +: 3];
				cmp_reg[sel_reg].drop <= pwdata[CST_DROP_BIT];
			end
			else if (wr_en && paddr == CST_CMP_TCOFF && tc_ok(cmp_reg[sel_reg].fmt, pwdata[22:0]))
				cmp_reg[sel_reg].tc_off <= pwdata[22:0];
		end
	end

	// Line and sample counters of each composite output.
	generate
		for (genvar i = 0; i < 2; i++)
		begin : g_pos
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					pos_reg[i] <= '0;
				else if (ref_start)
					pos_reg[i] <= preload(cmp_reg[i]);
				else if (sample_tick)
				begin
					if (32'(pos_reg[i].sample) >= (is_pal(cmp_reg[i].fmt) ? CST_H_PAL : CST_H_NTSC) - 1)
					begin
						pos_reg[i].sample <= '0;
						if (32'(pos_reg[i].line) >= (is_pal(cmp_reg[i].fmt) ? 2 * CST_V_PAL : 2 * CST_V_NTSC) - 1)
							pos_reg[i].line <= '0;
						else
							pos_reg[i].line <= pos_reg[i].line + 12'h001;
					end
					else
						pos_reg[i].sample <= pos_reg[i].sample + 12'h001;
				end
			end
			assign cmp_cfg[i] = cmp_reg[i];
			assign cmp_pos[i] = pos_reg[i];
		end
	endgenerate

	// Reference burst output settings.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int n = 0; n < CST_N_BLK; n++)
				blk_reg[n] <= blk_default();
		end
		else if (cmd_recall)
		begin
			for (int n = 0; n < CST_N_BLK; n++)
				blk_reg[n] <= blk_default();
		end
		else if (wr_en && blk_hit)
		begin
			if (blk_off == CST_BLK_FMT)
			begin
				blk_reg[blk_idx].fmt <= pwdata[1:0];
				blk_reg[blk_idx].fref <= pwdata[CST_FREF_BIT];
				blk_reg[blk_idx].tc_src <= pwdata[CST_SRC_LSB +: 3];
				blk_reg[blk_idx].drop <= pwdata[CST_DROP_BIT];
			end
			else if (blk_off == CST_BLK_VOFF)
				blk_reg[blk_idx].voff <= pwdata[11:0];
			else if (blk_off == CST_BLK_HOFF)
			begin
				blk_reg[blk_idx].coarse <= pwdata[15:0];
				if (32'(signed'(pwdata[23:16])) <= CST_FINE_MAX_NS && 32'(signed'(pwdata[23:16])) >= -CST_FINE_MAX_NS)
					blk_reg[blk_idx].fine <= pwdata[23:16];
			end
			else if (blk_off == CST_BLK_TCOFF && tc_ok(blk_reg[blk_idx].fmt, pwdata[22:0]))
				blk_reg[blk_idx].tc_off <= pwdata[22:0];
		end
	end

	// Field reference, timecode and drop frame are masked where they do not apply.
	generate
		for (genvar n = 0; n < CST_N_BLK; n++)
		begin : g_blk
			always_comb
			begin
				reference_burst_outputs[n] = blk_reg[n];
				if (blk_reg[n].fmt == CST_FMT_HD)
				begin
					reference_burst_outputs[n].fref = 1'b0;
					reference_burst_outputs[n].tc_src = '0;
				end
				if (blk_reg[n].fmt != CST_FMT_NTSC)
					reference_burst_outputs[n].drop = 1'b0;
			end
		end
	endgenerate

	// Blank-on-unlock and tri-level rate settings.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			blank_en_reg <= 1'b0;
			blank_dly_reg <= CST_BLANK_DLY_RST;
			tri_reg <= '0;
		end
		else if (cmd_recall)
		begin
			blank_en_reg <= 1'b0;
			blank_dly_reg <= CST_BLANK_DLY_RST;
			tri_reg <= '0;
		end
		else if (wr_en && paddr == CST_BLANK)
		begin
			blank_en_reg <= pwdata[CST_BLANK_EN_BIT];
			blank_dly_reg <= pwdata[16:0];
		end
		else if (wr_en && paddr == CST_TRI_RATE)
			tri_reg <= pwdata[1:0];
	end

	// Seconds of continuous unlock, counted only while blanking is armed.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sec_cnt_reg <= '0;
			unlock_sec_reg <= '0;
			blank_reg <= 1'b0;
		end
		else if (ref_locked || !blank_en_reg)
		begin
			sec_cnt_reg <= '0;
			unlock_sec_reg <= '0;
			blank_reg <= 1'b0;
		end
		else
		begin
			if (sec_cnt_reg >= 32'(SEC_CYCLES - 1))
			begin
				sec_cnt_reg <= '0;
				if (unlock_sec_reg != '1)
					unlock_sec_reg <= unlock_sec_reg + 17'h00001;
			end
			else
				sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
			blank_reg <= unlock_sec_reg >= blank_dly_reg;
		end
	end

	assign blank_second_output = blank_reg && reference_burst_outputs[CST_BLANK_OUT].fmt != CST_FMT_HD;
	assign tri_rate_low_integer = tri_reg[0];
	assign tri_rate_high_integer = tri_reg[1];
	assign cmp_sync_shock = shock_reg;
	assign composite_output_select = sel_reg;

	// Read data is captured in the setup phase and held through the access phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end
		else if (setup)
		begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
			if (paddr == CST_CTRL)
				prdata_reg <= {30'h0, ref_locked, sel_reg};
			else if (paddr == CST_CMP_FMT)
				prdata_reg <= {20'h0, cmp_reg[sel_reg].test, 6'h0, cmp_reg[sel_reg].fmt};
			else if (paddr == CST_CMP_VOFF)
				prdata_reg <= 32'(cmp_reg[sel_reg].voff);
			else if (paddr == CST_CMP_HOFF)
				prdata_reg <= 32'(cmp_reg[sel_reg].hoff);
			else if (paddr == CST_CMP_TC)
				prdata_reg <= {20'h0, cmp_reg[sel_reg].drop, cmp_reg[sel_reg].tc_src, 8'h0};
			else if (paddr == CST_CMP_TCOFF)
				prdata_reg <= {9'h0, cmp_reg[sel_reg].tc_off};
			else if (paddr == CST_CMP_POS)
				prdata_reg <= {4'h0, pos_reg[sel_reg].sample, 4'h0, pos_reg[sel_reg].line};
			else if (paddr == CST_BLANK)
				prdata_reg <= {11'h0, blank_en_reg, 3'h0, blank_dly_reg};
			else if (paddr == CST_TRI_RATE)
				prdata_reg <= {30'h0, tri_reg};
			else if (blk_hit && blk_off == CST_BLK_FMT)
				prdata_reg <= {20'h0, blk_reg[blk_idx].drop, blk_reg[blk_idx].tc_src, 3'h0,
					blk_reg[blk_idx].fref, 2'h0, blk_reg[blk_idx].fmt};
			else if (blk_hit && blk_off == CST_BLK_VOFF)
				prdata_reg <= 32'(blk_reg[blk_idx].voff);
			else if (blk_hit && blk_off == CST_BLK_HOFF)
				prdata_reg <= {8'h0, blk_reg[blk_idx].fine, blk_reg[blk_idx].coarse};
			else if (blk_hit && blk_off == CST_BLK_TCOFF)
				prdata_reg <= {9'h0, blk_reg[blk_idx].tc_off};
			else
				pslverr_reg <= 1'b1;
		end
	end
endmodule : cst_timing

// >>> cst_timing_chk.sv
// Concurrent checks on the ports of the composite sync timing offset block.
// Assumes it is bound to cst_timing and sees only that module's ports.
`timescale 1ns/10ps
module cst_timing_chk
	import cst_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// Watched outputs
	input wire cst_cmp_type [1:0] cmp_cfg,
	input wire logic [1:0] cmp_sync_shock,
	input wire logic composite_output_select,
	input wire cst_blk_type [CST_N_BLK-1:0] reference_burst_outputs,
	input wire logic blank_second_output,
	input wire logic tri_rate_low_integer,
	input wire logic tri_rate_high_integer
);
	localparam cst_blk_type BDEF = '{drop: 1'b1, default: '0};
	logic ctrl_wr;
	logic fmt_wr;
	logic blk_def;
	logic blk_mask;
	assign ctrl_wr = psel && penable && pwrite && paddr == CST_CTRL;
	assign fmt_wr = psel && penable && pwrite && paddr == CST_CMP_FMT;
	always_comb
	begin
		cst_blk_type b;
		b = '0;
		blk_def = 1'b1;
		blk_mask = 1'b1;
		for (int i = 0; i < CST_N_BLK; i++)
		begin
			b = reference_burst_outputs[i];
			if (b != BDEF)
				blk_def = 1'b0;
			if ((b.fmt == CST_FMT_HD && (b.fref || b.tc_src != 3'h0)) || (b.fmt != CST_FMT_NTSC && b.drop))
				blk_mask = 1'b0;
		end
	end
	function automatic bit in_rng(cst_cmp_type c, int k);
		int vl, hl;
		vl = c.fmt == CST_FMT_PAL ? CST_V_PAL : CST_V_NTSC;
		hl = c.fmt == CST_FMT_PAL ? CST_H_PAL : CST_H_NTSC;
		case (k)
			0: return c.voff >= -vl && c.voff <= vl;
			1: return c.hoff >= -hl && c.hoff <= hl;
			default: return c.test < (c.fmt == CST_FMT_PAL ? CST_TEST_PAL_CNT : CST_TEST_NTSC_CNT);
		endcase
	endfunction : in_rng
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_voff_range; in_rng(cmp_cfg[0], 0) && in_rng(cmp_cfg[1], 0); endproperty
	a_voff_range: assert property (p_voff_range) else $error("vertical offset out of range");
	property p_hoff_range; in_rng(cmp_cfg[0], 1) && in_rng(cmp_cfg[1], 1); endproperty
	a_hoff_range: assert property (p_hoff_range) else $error("horizontal offset out of range");
	property p_test_range; in_rng(cmp_cfg[0], 2) && in_rng(cmp_cfg[1], 2); endproperty
	a_test_range: assert property (p_test_range) else $error("test signal not offered by format");
	property p_clear;
		ctrl_wr && pwdata[CST_CTRL_OFF_CLR] && !pwdata[CST_CTRL_RECALL] && !pwdata[CST_CTRL_SEL_ADV] |=>
			cmp_cfg[$past(composite_output_select)].voff == 0 && cmp_cfg[$past(composite_output_select)].hoff == 0;
	endproperty
	a_clear: assert property (p_clear) else $error("offset clear missed");
	property p_sel_adv;
		ctrl_wr && pwdata[CST_CTRL_SEL_ADV] && !pwdata[CST_CTRL_RECALL] |=>
			composite_output_select != $past(composite_output_select);
	endproperty
	a_sel_adv: assert property (p_sel_adv) else $error("output select did not advance");
	property p_sel_hold; !ctrl_wr |=> $stable(composite_output_select); endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("output select moved by itself");
	property p_recall;
		ctrl_wr && pwdata[CST_CTRL_RECALL] |=> blk_def && !tri_rate_low_integer && !tri_rate_high_integer
			##1 !blank_second_output;
	endproperty
	a_recall: assert property (p_recall) else $error("factory recall left a setting");
	property p_blk_mask; blk_mask; endproperty
	a_blk_mask: assert property (p_blk_mask) else $error("black output setting active in wrong format");
	property p_shock; $past(fmt_wr) && $changed(cmp_cfg[0].fmt) |-> ##[0:1] cmp_sync_shock[0]; endproperty
	a_shock: assert property (p_shock) else $error("format change without sync shock");
endmodule : cst_timing_chk

bind cst_timing cst_timing_chk cst_timing_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cmp_cfg(cmp_cfg), .cmp_sync_shock(cmp_sync_shock),
	.composite_output_select(composite_output_select), .reference_burst_outputs(reference_burst_outputs),
	.blank_second_output(blank_second_output), .tri_rate_low_integer(tri_rate_low_integer),
	.tri_rate_high_integer(tri_rate_high_integer));

// >>> cst_timing_tb.sv
// Self-checking bench for the composite sync timing offset block.
// Assumes the checker is bound in and the sink model counts shocks.
`timescale 1ns/10ps
module cst_timing_tb
	import cst_pkg::*;
;
	// A short second keeps the blank test brief.
	localparam int SEC = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic sample_tick, int_frame_start, genlock_frame_pin, genlock_locked_pin;
	logic [7:0] paddr;
	logic [7:0] shock_count;
	logic [31:0] pwdata, prdata, rdat;
	cst_cmp_type [1:0] cmp_cfg;
	cst_pos_type [1:0] cmp_pos;
	logic [1:0] cmp_sync_shock;
	logic composite_output_select, blank_second_output, tri_rate_low_integer, tri_rate_high_integer;
	cst_blk_type [CST_N_BLK-1:0] reference_burst_outputs;
	int err_total;
	int check_count;
	always #2 pclk = ~pclk;
	cst_timing #(.SEC_CYCLES(SEC)) cst_timing_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_tick(sample_tick), .int_frame_start(int_frame_start), .genlock_frame_pin(genlock_frame_pin),
		.genlock_locked_pin(genlock_locked_pin), .cmp_cfg(cmp_cfg), .cmp_pos(cmp_pos),
		.cmp_sync_shock(cmp_sync_shock), .composite_output_select(composite_output_select),
		.reference_burst_outputs(reference_burst_outputs), .blank_second_output(blank_second_output),
		.tri_rate_low_integer(tri_rate_low_integer), .tri_rate_high_integer(tri_rate_high_integer));
	cst_video_sink cst_video_sink_i (.pclk(pclk), .presetn(presetn), .cmp_sync_shock(cmp_sync_shock),
		.shock_count(shock_count));
	task stop_test;
		$display("errors %0d checks %0d", err_total, check_count);
		if (err_total == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [79:0] g, input logic [79:0] e);
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			err_total++;
			stop_test;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task pulse(input int k);
		@(posedge pclk);
		case (k)
			0: sample_tick <= 1'b1;
			1: int_frame_start <= 1'b1;
			default: genlock_frame_pin <= 1'b1;
		endcase
		@(posedge pclk);
		sample_tick <= 1'b0;
		int_frame_start <= 1'b0;
		genlock_frame_pin <= 1'b0;
		repeat (5) @(posedge pclk);
	endtask : pulse
	function automatic int vlim(logic [1:0] f);
		return f == CST_FMT_PAL ? CST_V_PAL : CST_V_NTSC;
	endfunction : vlim
	function automatic int hlim(logic [1:0] f);
		return f == CST_FMT_PAL ? CST_H_PAL : CST_H_NTSC;
	endfunction : hlim
	function automatic logic [79:0] epos(logic [1:0] f, int v, int h, int t);
		int l, s;
		l = v;
		s = h + t;
		if (s < 0)
		begin
			s += hlim(f);
			l--;
		end
		if (s >= hlim(f))
		begin
			s -= hlim(f);
			l++;
		end
		if (l < 0)
			l += 2 * vlim(f);
		if (l >= 2 * vlim(f))
			l -= 2 * vlim(f);
		return {56'h0, 12'(l), 12'(s)};
	endfunction : epos
	function automatic bit tc_ok(logic [1:0] f, cst_tc_type t);
		return t.hh <= CST_TC_HH_MAX && t.mm <= CST_TC_MS_MAX && t.ss <= CST_TC_MS_MAX &&
			t.ff <= (f == CST_FMT_PAL ? CST_TC_FF_PAL : CST_TC_FF_NTSC);
	endfunction : tc_ok
	initial
	begin
		int f, lim, cur, v, h, n;
		cst_blk_type bd;
		cst_tc_type tcur;
		cst_tc_type tcs [6];
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{sample_tick, int_frame_start, genlock_frame_pin, genlock_locked_pin} = 4'h0;
		err_total = 0;
		check_count = 0;
		void'($urandom(69));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		bd = '{drop: 1'b1, default: '0};
		for (int i = 0; i < CST_N_BLK; i++)
			chk(reference_burst_outputs[i], bd);
		chk({blank_second_output, tri_rate_low_integer, tri_rate_high_integer}, 3'h0);
		apb(0, CST_BLANK, 32'h0);
		chk(rdat, 32'h0000000A);
		apb(0, CST_CMP_TC, 32'h0);
		chk(rdat, 32'h00000800);
		apb(0, 8'h3C, 32'h0);
		chk(rerr, 1'b1);
		for (f = 0; f < 3; f++)
		begin
			for (int t = 0; t < 16; t++)
			begin
				apb(1, CST_CMP_FMT, (t << CST_TEST_LSB) | f);
				chk(cmp_cfg[0].test, t < (f == CST_FMT_PAL ? CST_TEST_PAL_CNT : CST_TEST_NTSC_CNT) ? t : 0);
			end
			for (int r = 0; r < 2; r++)
			begin
				lim = r ? hlim(f[1:0]) : vlim(f[1:0]);
				cur = 0;
				for (int k = 0; k < 5; k++)
				begin
					v = k[1] ? -lim - int'(k[0]) : lim + int'(k[0]);
					if (k == 4)
						v = int'($urandom_range(2 * lim)) - lim;
					apb(1, r ? CST_CMP_HOFF : CST_CMP_VOFF, v);
					if (v >= -lim && v <= lim)
						cur = v;
					chk(r ? 80'(cmp_cfg[0].hoff) : 80'(cmp_cfg[0].voff), 80'(cur));
				end
			end
			for (int k = 0; k < 4; k++)
			begin
				v = k == 1 ? -vlim(f[1:0]) : int'($urandom_range(2 * vlim(f[1:0]))) - vlim(f[1:0]);
				h = k == 0 ? -1 : int'($urandom_range(2 * hlim(f[1:0]) - 1)) - hlim(f[1:0]);
				apb(1, CST_CMP_VOFF, v);
				apb(1, CST_CMP_HOFF, h);
				pulse(1);
				chk(cmp_pos[0], epos(f[1:0], v, h, 0));
				pulse(0);
				chk(cmp_pos[0], epos(f[1:0], v, h, 1));
			end
		end
		chk(shock_count, 8'h02);
		genlock_locked_pin <= 1'b1;
		apb(1, CST_CMP_HOFF, 32'h7);
		rdat = {8'h0, cmp_pos[0]};
		pulse(1);
		chk(cmp_pos[0], rdat[23:0]);
		pulse(2);
		chk(cmp_pos[0], epos(CST_FMT_PAL, v, 7, 0));
		genlock_locked_pin <= 1'b0;
		apb(1, CST_CTRL, 32'h1);
		chk(composite_output_select, 1'b1);
		apb(1, CST_CMP_VOFF, 32'hFFFFFFF7);
		apb(1, CST_CMP_HOFF, 32'h4);
		chk({cmp_cfg[1].voff, cmp_cfg[1].hoff, cmp_cfg[0].voff}, {12'hFF7, 13'h4, 12'(v)});
		apb(1, CST_CTRL, 32'h2);
		chk({cmp_cfg[1].voff, cmp_cfg[1].hoff, cmp_cfg[0].hoff}, {25'h0, 13'h7});
		apb(1, CST_CTRL, 32'h1);
		apb(0, CST_CTRL, 32'h0);
		chk(rdat[0], 1'b0);
		tcs = '{'{1'b0, 5'h17, 6'h3B, 6'h3B, 5'h18}, '{1'b1, 5'h01, 6'h02, 6'h03, 5'h19},
			'{1'b0, 5'h18, 6'h00, 6'h00, 5'h00}, '{1'b1, 5'h17, 6'h3B, 6'h3B, 5'h1D},
			'{1'b0, 5'h00, 6'h3C, 6'h00, 5'h00}, '{1'b0, 5'h00, 6'h00, 6'h3C, 5'h1D}};
		f = CST_FMT_PAL;
		tcur = '0;
		for (int k = 0; k < 6; k++)
		begin
			if (k == 3)
			begin
				f = CST_FMT_NTSC;
				apb(1, CST_CMP_FMT, f);
			end
			apb(1, CST_CMP_TCOFF, 32'(tcs[k]));
			if (tc_ok(f[1:0], tcs[k]))
				tcur = tcs[k];
			chk(cmp_cfg[0].tc_off, tcur);
		end
		apb(1, CST_BLK_BASE + 8'h20, 32'h00000F13);
		chk(reference_burst_outputs[2], {2'h3, 64'h0});
		apb(1, CST_BLK_BASE, 32'h00000B12);
		chk(reference_burst_outputs[0], {2'h2, 1'b1, 36'h0, 3'h3, 1'b0, 23'h0});
		apb(1, CST_TRI_RATE, 32'h1);
		chk({tri_rate_low_integer, tri_rate_high_integer}, 2'h2);
		genlock_locked_pin <= 1'b1;
		apb(1, CST_BLANK, 32'h00100002);
		repeat (4) @(posedge pclk);
		chk(blank_second_output, 1'b0);
		genlock_locked_pin <= 1'b0;
		n = 0;
		while (blank_second_output !== 1'b1 && n < 100)
		begin
			@(posedge pclk);
			n++;
		end
		if (n >= 100)
		begin
			err_total++;
			stop_test;
		end
		chk(n >= 2 * SEC - 2 && n <= 2 * SEC + 8, 1'b1);
		apb(1, CST_CTRL, 32'h4);
		@(posedge pclk);
		for (int i = 0; i < CST_N_BLK; i++)
			chk(reference_burst_outputs[i], bd);
		chk({blank_second_output, tri_rate_low_integer, tri_rate_high_integer}, 3'h0);
		stop_test;
	end
endmodule : cst_timing_tb

// >>> cst_video_sink.sv
// Downstream video equipment locked to the composite outputs.
// Assumes it runs on pclk beside the generator block.
`timescale 1ns/10ps
module cst_video_sink
	import cst_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Composite sync disturbance
	input wire logic [1:0] cmp_sync_shock,
	// Status
	output logic [7:0] shock_count
);
	// Each shock is a momentary lock loss; the sink relocks and only counts it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shock_count <= 8'h00;
		else
			shock_count <= shock_count + 8'(cmp_sync_shock[0]) + 8'(cmp_sync_shock[1]);
	end
endmodule : cst_video_sink
